// file: logic/sid_pkg.sv
`default_nettype none
package sid_pkg;
  // apb byte offsets
  localparam logic [7:0] SID_CTRL_OFS = 8'h00;
  localparam logic [7:0] SID_BLKNUM_OFS = 8'h04;
  localparam logic [7:0] SID_STATUS_OFS = 8'h08;
  localparam logic [7:0] SID_QUOT_OFS = 8'h0C;
  localparam logic [7:0] SID_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] SID_IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] SID_IRQ_CLR_OFS = 8'h18;

  // ctrl field positions
  localparam int SID_CTRL_DVD_FMT_LSB = 0;
  localparam int SID_CTRL_DVS_FMT_LSB = 2;
  localparam int SID_CTRL_OUT_FMT_LSB = 4;
  localparam int SID_CTRL_DVD_ACT_BIT = 6;
  localparam int SID_CTRL_DVS_ACT_BIT = 7;
  localparam int SID_CTRL_RND_LSB = 8;
  localparam int SID_CTRL_MAP_STATE_BIT = 10;
  localparam int SID_CTRL_MAP_DIAG_BIT = 11;
  localparam int SID_CTRL_WIDTH = 12;
  localparam logic [11:0] SID_CTRL_RESET = 12'h0C5;

  // status field positions
  localparam int SID_STAT_STATE_LSB = 0;
  localparam int SID_STAT_DIAG_LSB = 4;
  localparam int SID_STAT_ERR_BIT = 6;

  // irq bit positions
  localparam int SID_IRQ_UNDER_BIT = 0;
  localparam int SID_IRQ_OVER_BIT = 1;
  localparam int SID_IRQ_ZERO_BIT = 2;
  localparam int SID_IRQ_RESET_BIT = 3;
  localparam int SID_IRQ_WIDTH = 4;

  localparam logic [15:0] SID_BLKNUM_RESET = 16'h0001;

  // integer formats
  typedef enum logic [1:0] {
    SID_FMT_INT16 = 2'h0,
    SID_FMT_INT32 = 2'h1,
    SID_FMT_UINT16 = 2'h2,
    SID_FMT_UINT32 = 2'h3
  } sid_fmt_t;

  // rounding methods
  typedef enum logic [1:0] {
    SID_RND_FLOOR = 2'h0,
    SID_RND_CEIL = 2'h1,
    SID_RND_ROUND = 2'h2,
    SID_RND_SPARE = 2'h3
  } sid_rnd_t;

  // state machine, gray along stop-run-error-reset
  typedef enum logic [2:0] {
    SID_ST_STOP = 3'h0,
    SID_ST_RUN = 3'h1,
    SID_ST_ERROR = 3'h3,
    SID_ST_RESET = 3'h2
  } sid_state_t;

  // presented state codes
  localparam logic [2:0] SID_CODE_RUN = 3'h1;
  localparam logic [2:0] SID_CODE_STOP = 3'h2;
  localparam logic [2:0] SID_CODE_ERROR = 3'h4;
  localparam logic [2:0] SID_CODE_RESET = 3'h5;

  // diagnostic codes
  localparam logic [1:0] SID_DIAG_OK = 2'h0;
  localparam logic [1:0] SID_DIAG_UNDER = 2'h1;
  localparam logic [1:0] SID_DIAG_OVER = 2'h2;

  // diagnostic message text ids
  localparam logic [15:0] SID_TEXT_UNDER = 16'h4080;
  localparam logic [15:0] SID_TEXT_OVER = 16'h4081;

  // output range limits, 35-bit signed
  localparam logic signed [34:0] SID_MIN_INT16 = -35'sh0000_8000;
  localparam logic signed [34:0] SID_MAX_INT16 = 35'sh0000_7FFF;
  localparam logic signed [34:0] SID_MIN_INT32 = -35'sh0_8000_0000;
  localparam logic signed [34:0] SID_MAX_INT32 = 35'sh0_7FFF_FFFF;
  localparam logic signed [34:0] SID_MAX_UINT16 = 35'sh0000_FFFF;
  localparam logic signed [34:0] SID_MAX_UINT32 = 35'sh0_FFFF_FFFF;
  localparam logic signed [34:0] SID_MIN_UNSIGNED = 35'sh0;
endpackage
`default_nettype wire

// file: logic/sid_divide_block.sv
`default_nettype none
module sid_divide_block (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic logic_cycle_tick,
  input wire logic [31:0] dividend_in,
  input wire logic [31:0] divisor_in,
  input wire logic block_run_enable,
  input wire logic group_error_acknowledge,
  output logic [31:0] quotient_out,
  output logic error_out,
  output logic [2:0] state_code_out,
  output logic [1:0] diag_code_out,
  output logic [2:0] state_to_image,
  output logic [1:0] diagnostic_to_image,
  output logic diag_msg_valid,
  output logic [15:0] diag_msg_text_id,
  output logic [15:0] diag_msg_block_num,
  output logic [31:0] diag_msg_param_dividend,
  output logic [31:0] diag_msg_param_divisor,
  output logic irq
);

  // sign or zero extension by format, inactive port reads zero
  function automatic logic signed [33:0] sid_extend(input logic [31:0] v,
                                                    input logic [1:0] fmt,
                                                    input logic act);
    logic signed [33:0] e;
    e = 34'sh0;
    if (act) begin
      unique case (fmt)
        sid_pkg::SID_FMT_INT16: e = {{18{v[15]}}, v[15:0]};
        sid_pkg::SID_FMT_INT32: e = {{2{v[31]}}, v};
        sid_pkg::SID_FMT_UINT16: e = {18'h0, v[15:0]};
        sid_pkg::SID_FMT_UINT32: e = {2'h0, v};
      endcase
    end
    return e;
  endfunction

  // magnitude of an extended operand
  function automatic logic [31:0] sid_mag(input logic signed [33:0] e);
    logic [33:0] m;
    m = e[33] ? 34'(-e) : 34'(e);
    return m[31:0];
  endfunction

  // state code seen from outside
  function automatic logic [2:0] sid_code(input sid_pkg::sid_state_t s);
    logic [2:0] c;
    c = sid_pkg::SID_CODE_ERROR;
    unique case (s)
      sid_pkg::SID_ST_STOP: c = sid_pkg::SID_CODE_STOP;
      sid_pkg::SID_ST_RUN: c = sid_pkg::SID_CODE_RUN;
      sid_pkg::SID_ST_ERROR: c = sid_pkg::SID_CODE_ERROR;
      sid_pkg::SID_ST_RESET: c = sid_pkg::SID_CODE_RESET;
      default: c = sid_pkg::SID_CODE_ERROR;
    endcase
    return c;
  endfunction

  // configuration and status registers
  logic [11:0] ctrl_r;
  logic [15:0] blknum_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_en_r;
  sid_pkg::sid_state_t state_r;
  sid_pkg::sid_state_t state_nxt;
  logic [31:0] quot_r;
  logic [31:0] quot_nxt;
  logic err_r;
  logic [1:0] diag_r;
  logic [1:0] diag_nxt;
  logic msg_r;
  logic [15:0] msg_text_r;
  logic [31:0] msg_dvd_r;
  logic [31:0] msg_dvs_r;

  // apb decode
  wire logic apb_acc = psel & penable;
  wire logic apb_wr = apb_acc & pwrite;
  wire logic hit_ctrl = paddr == sid_pkg::SID_CTRL_OFS;
  wire logic hit_blk = paddr == sid_pkg::SID_BLKNUM_OFS;
  wire logic hit_stat = paddr == sid_pkg::SID_STATUS_OFS;
  wire logic hit_quot = paddr == sid_pkg::SID_QUOT_OFS;
  wire logic hit_istat = paddr == sid_pkg::SID_IRQ_STAT_OFS;
  wire logic hit_ien = paddr == sid_pkg::SID_IRQ_EN_OFS;
  wire logic hit_iclr = paddr == sid_pkg::SID_IRQ_CLR_OFS;
  wire logic hit_any = hit_ctrl | hit_blk | hit_stat | hit_quot | hit_istat | hit_ien
                       | hit_iclr;
  wire logic ctrl_we = apb_wr & hit_ctrl;
  wire logic blk_we = apb_wr & hit_blk;
  wire logic ien_we = apb_wr & hit_ien;
  wire logic iclr_we = apb_wr & hit_iclr;
  wire logic rd_en = apb_acc & ~pwrite;

  // configuration fields
  wire logic [1:0] dvd_fmt = ctrl_r[sid_pkg::SID_CTRL_DVD_FMT_LSB +: 2];
  wire logic [1:0] dvs_fmt = ctrl_r[sid_pkg::SID_CTRL_DVS_FMT_LSB +: 2];
  wire logic [1:0] out_fmt = ctrl_r[sid_pkg::SID_CTRL_OUT_FMT_LSB +: 2];
  wire logic dvd_act = ctrl_r[sid_pkg::SID_CTRL_DVD_ACT_BIT];
  wire logic dvs_act = ctrl_r[sid_pkg::SID_CTRL_DVS_ACT_BIT];
  wire logic [1:0] rnd = ctrl_r[sid_pkg::SID_CTRL_RND_LSB +: 2];
  wire logic map_state = ctrl_r[sid_pkg::SID_CTRL_MAP_STATE_BIT];
  wire logic map_diag = ctrl_r[sid_pkg::SID_CTRL_MAP_DIAG_BIT];

  // operands
  wire logic signed [33:0] a_ext = sid_extend(dividend_in, dvd_fmt, dvd_act);
  wire logic signed [33:0] b_ext = sid_extend(divisor_in, dvs_fmt, dvs_act);
  wire logic [31:0] a_mag = sid_mag(a_ext);
  wire logic [31:0] b_mag = sid_mag(b_ext);
  wire logic b_zero = b_mag == 32'h0;

  // unsigned division of magnitudes
  wire logic [31:0] q_mag = b_zero ? 32'h0 : a_mag / b_mag;
  wire logic [31:0] r_mag = b_zero ? 32'h0 : a_mag % b_mag;
  wire logic r_nz = r_mag != 32'h0;
  wire logic res_neg = (a_ext[33] ^ b_ext[33]) & (q_mag != 32'h0 | r_nz);

  // rounding: magnitude grows for ceil on positive, or half and above
  wire logic half_up = {r_mag, 1'b0} >= {1'b0, b_mag};
  wire logic up_ceil = r_nz & ~res_neg;
  wire logic up_round = r_nz & half_up;
  wire logic up = (rnd == sid_pkg::SID_RND_CEIL) ? up_ceil :
                  (rnd == sid_pkg::SID_RND_ROUND) ? up_round : 1'b0;
  wire logic [32:0] res_mag = {1'b0, q_mag} + {32'h0, up};
  wire logic signed [34:0] res_pos = {2'b00, res_mag};
  wire logic signed [34:0] res = res_neg ? 35'(-res_pos) : res_pos;

  // output range of the configured result type
  logic signed [34:0] lim_min;
  logic signed [34:0] lim_max;
  always_comb begin
    lim_min = sid_pkg::SID_MIN_UNSIGNED;
    lim_max = sid_pkg::SID_MAX_UINT32;
    unique case (out_fmt)
      sid_pkg::SID_FMT_INT16: begin
        lim_min = sid_pkg::SID_MIN_INT16;
        lim_max = sid_pkg::SID_MAX_INT16;
      end
      sid_pkg::SID_FMT_INT32: begin
        lim_min = sid_pkg::SID_MIN_INT32;
        lim_max = sid_pkg::SID_MAX_INT32;
      end
      sid_pkg::SID_FMT_UINT16: begin
        lim_min = sid_pkg::SID_MIN_UNSIGNED;
        lim_max = sid_pkg::SID_MAX_UINT16;
      end
      sid_pkg::SID_FMT_UINT32: begin
        lim_min = sid_pkg::SID_MIN_UNSIGNED;
        lim_max = sid_pkg::SID_MAX_UINT32;
      end
    endcase
  end

  // zero divisor is exempt from the range check
  wire logic under = ~b_zero & (res < lim_min);
  wire logic over = ~b_zero & (res > lim_max);
  wire logic range_err = under | over;
  wire logic [31:0] res_word = b_zero ? 32'h0 : res[31:0];

  // state transitions, taken once per logic cycle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sid_pkg::SID_ST_STOP: begin
        if (block_run_enable) begin
          state_nxt = range_err ? sid_pkg::SID_ST_ERROR : sid_pkg::SID_ST_RUN;
        end
      end
      sid_pkg::SID_ST_RUN: begin
        if (!block_run_enable) begin
          state_nxt = sid_pkg::SID_ST_STOP;
        end else if (range_err) begin
          state_nxt = sid_pkg::SID_ST_ERROR;
        end
      end
      sid_pkg::SID_ST_ERROR: begin
        // run enable ignored, only the acknowledge while the range check passes leaves error
        if (!range_err && group_error_acknowledge) begin
          state_nxt = sid_pkg::SID_ST_RESET;
        end
      end
      sid_pkg::SID_ST_RESET: begin
        if (!block_run_enable) begin
          state_nxt = sid_pkg::SID_ST_STOP;
        end else if (range_err) begin
          state_nxt = sid_pkg::SID_ST_ERROR;
        end else begin
          state_nxt = sid_pkg::SID_ST_RUN;
        end
      end
      default: state_nxt = sid_pkg::SID_ST_ERROR;
    endcase
  end

  // quotient and error outputs follow the next state, diag code follows the range check
  wire logic nxt_run = state_nxt == sid_pkg::SID_ST_RUN;
  wire logic nxt_err = state_nxt == sid_pkg::SID_ST_ERROR;
  wire logic enter_err = logic_cycle_tick & nxt_err & (state_r != sid_pkg::SID_ST_ERROR);
  wire logic enter_rst = logic_cycle_tick & (state_nxt == sid_pkg::SID_ST_RESET)
                         & (state_r != sid_pkg::SID_ST_RESET);
  assign quot_nxt = nxt_run ? res_word : 32'h0;
  assign diag_nxt = under ? sid_pkg::SID_DIAG_UNDER :
                    over ? sid_pkg::SID_DIAG_OVER : sid_pkg::SID_DIAG_OK;

  // state register, moves at the end of each logic cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= sid_pkg::SID_ST_STOP;
    end else if (logic_cycle_tick) begin
      state_r <= state_nxt;
    end
  end

  // datapath outputs, updated together with the state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      quot_r <= 32'h0;
      err_r <= 1'b0;
      diag_r <= sid_pkg::SID_DIAG_OK;
    end else if (logic_cycle_tick) begin
      quot_r <= quot_nxt;
      err_r <= nxt_err;
      diag_r <= diag_nxt;
    end
  end

  // diagnostic message pulse to the owning group
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_r <= 1'b0;
    end else begin
      msg_r <= enter_err;
    end
  end

  // message payload, captured on error entry
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_text_r <= 16'h0;
      msg_dvd_r <= 32'h0;
      msg_dvs_r <= 32'h0;
    end else if (enter_err) begin
      msg_text_r <= under ? sid_pkg::SID_TEXT_UNDER : sid_pkg::SID_TEXT_OVER;
      msg_dvd_r <= dividend_in;
      msg_dvs_r <= divisor_in;
    end
  end

  // events into sticky status, set wins over clear
  wire logic [3:0] ev_set = {enter_rst, logic_cycle_tick & b_zero & nxt_run,
                             enter_err & over, enter_err & under};
  wire logic [3:0] ev_clr = iclr_we ? pwdata[3:0] : 4'h0;

  // control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= sid_pkg::SID_CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_r <= pwdata[11:0];
    end
  end

  // block number
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      blknum_r <= sid_pkg::SID_BLKNUM_RESET;
    end else if (blk_we) begin
      blknum_r <= pwdata[15:0];
    end
  end

  // interrupt enable
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= 4'h0;
    end else if (ien_we) begin
      irq_en_r <= pwdata[3:0];
    end
  end

  // sticky interrupt status
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= 4'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;
    end
  end

  // read mux
  wire logic [31:0] stat_word = {25'h0, err_r, diag_r, 1'b0, sid_code(state_r)};
  assign prdata = !rd_en ? 32'h0 :
                  hit_ctrl ? {20'h0, ctrl_r} :
                  hit_blk ? {16'h0, blknum_r} :
                  hit_stat ? stat_word :
                  hit_quot ? quot_r :
                  hit_istat ? {28'h0, irq_stat_r} :
                  hit_ien ? {28'h0, irq_en_r} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;

  // block outputs
  assign quotient_out = quot_r;
  assign error_out = err_r;
  assign state_code_out = sid_code(state_r);
  assign diag_code_out = diag_r;
  assign state_to_image = map_state ? sid_code(state_r) : 3'h0;
  assign diagnostic_to_image = map_diag ? diag_r : 2'h0;
  assign diag_msg_valid = msg_r;
  assign diag_msg_text_id = msg_text_r;
  assign diag_msg_block_num = blknum_r;
  assign diag_msg_param_dividend = msg_dvd_r;
  assign diag_msg_param_divisor = msg_dvs_r;
  assign irq = |(irq_stat_r & irq_en_r);

endmodule // sid_divide_block
`default_nettype wire

// file: dv/sid_divide_block_properties.sv
`default_nettype none
module sid_divide_block_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic logic_cycle_tick,
  input wire logic [31:0] divisor_in,
  input wire logic block_run_enable,
  input wire logic group_error_acknowledge,
  input wire logic [31:0] quotient_out,
  input wire logic error_out,
  input wire logic [2:0] state_code_out,
  input wire logic diag_msg_valid,
  input wire logic [15:0] diag_msg_text_id
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic in_err = state_code_out == sid_pkg::SID_CODE_ERROR;
  property p_err_flag; error_out == in_err; endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag off");
  property p_zero_out; state_code_out != sid_pkg::SID_CODE_RUN |-> quotient_out == 32'h0;
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("result not zero");
  property p_codes;
    state_code_out inside {3'h1, 3'h2, 3'h4, 3'h5};
  endproperty
  a_codes: assert property (p_codes) else $error("bad state code");
  property p_hold;
    !logic_cycle_tick |=> $stable(state_code_out) && $stable(quotient_out);
  endproperty
  a_hold: assert property (p_hold) else $error("change without tick");
  property p_stop;
    logic_cycle_tick && !block_run_enable && !in_err |=> state_code_out == 3'h2;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_err_hold; logic_cycle_tick && in_err && !group_error_acknowledge |=> in_err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("left error early");
  property p_zero_div;
    logic_cycle_tick && block_run_enable && !in_err && divisor_in == 32'h0
      |=> !error_out && quotient_out == 32'h0;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("zero divisor");
  property p_msg; $rose(error_out) |-> ##[0:1] diag_msg_valid; endproperty
  a_msg: assert property (p_msg) else $error("no message");
  property p_pulse;
    diag_msg_valid |-> (diag_msg_text_id == 16'h4080 || diag_msg_text_id == 16'h4081)
      ##1 !diag_msg_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad message");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  c_err: cover property ($rose(error_out));
  c_reset: cover property (state_code_out == 3'h5);
  c_zero: cover property (logic_cycle_tick && block_run_enable && divisor_in == 32'h0);
endmodule // sid_divide_block_properties
`default_nettype wire

// file: dv/sid_group_model.sv
`default_nettype none
module sid_group_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic diag_msg_valid,
  input wire logic error_out,
  input wire logic [3:0] ack_delay,
  output logic group_error_acknowledge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_r;
  // ack some cycles after a message, drop once the error is gone
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h0;
      group_error_acknowledge <= 1'b0;
    end else if (diag_msg_valid) begin
      cnt_r <= {1'b0, ack_delay} + 5'h1;
    end else if (cnt_r == 5'h1) begin
      cnt_r <= 5'h0;
      group_error_acknowledge <= 1'b1;
    end else if (cnt_r != 5'h0) begin
      cnt_r <= cnt_r - 5'h1;
    end else if (!error_out) begin
      group_error_acknowledge <= 1'b0;
    end
  end
endmodule // sid_group_model
`default_nettype wire

// file: dv/sid_divide_block_tb_top.sv
`default_nettype none
module sid_divide_block_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] C_RUN = sid_pkg::SID_CODE_RUN;
  localparam logic [2:0] C_STOP = sid_pkg::SID_CODE_STOP;
  localparam logic [2:0] C_ERR = sid_pkg::SID_CODE_ERROR;
  localparam logic [2:0] C_RST = sid_pkg::SID_CODE_RESET;
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic logic_cycle_tick = 1'b0, block_run_enable = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, dividend_in = 32'h0, divisor_in = 32'h0;
  logic [3:0] ack_delay = 4'h0, exp_irq = 4'h0;
  wire logic group_error_acknowledge, pready, pslverr, error_out, diag_msg_valid, irq;
  wire logic [31:0] prdata, quotient_out, diag_msg_param_dividend, diag_msg_param_divisor;
  wire logic [2:0] state_code_out, state_to_image;
  wire logic [1:0] diag_code_out, diagnostic_to_image;
  wire logic [15:0] diag_msg_text_id, diag_msg_block_num;
  int seed = 7949, failures = 0, n_tests = 0, n_msg = 0, n_exp = 0;
  logic [2:0] st = 3'h2;
  logic [11:0] ctrl = 12'h0C5;
  logic [15:0] blk = 16'h1, exp_text = 16'h0;
  logic [31:0] exp_a = 32'h0, exp_b = 32'h0;
  logic [32:0] r;
  logic [31:0] ca [5] = '{32'h5, 32'hFFFF_FFFB, 32'h7, 32'h8000_0000, 32'h9};
  logic [31:0] cb [5] = '{32'h2, 32'h2, 32'h0, 32'hFFFF_FFFF, 32'h4};
  sid_divide_block u_dut (
    .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .logic_cycle_tick, .dividend_in, .divisor_in, .block_run_enable,
    .group_error_acknowledge, .quotient_out, .error_out, .state_code_out, .diag_code_out,
    .state_to_image, .diagnostic_to_image, .diag_msg_valid, .diag_msg_text_id,
    .diag_msg_block_num, .diag_msg_param_dividend, .diag_msg_param_divisor, .irq
  );
  sid_group_model u_group (
    .sys_clk, .rst_b, .diag_msg_valid, .error_out, .ack_delay, .group_error_acknowledge
  );
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic longint ext(input logic [31:0] v, input logic [1:0] f);
    case (f)
      2'h0: return longint'($signed(v[15:0]));
      2'h1: return longint'($signed(v));
      2'h2: return longint'(v[15:0]);
      default: return longint'(v);
    endcase
  endfunction
  // diag code and result for one tick
  function automatic logic [33:0] exp_div(input logic [31:0] a, b, input logic [11:0] c);
    longint x, y, q, m, lo, hi;
    logic [1:0] d;
    x = ext(c[6] ? a : 32'h0, c[1:0]);
    y = ext(c[7] ? b : 32'h0, c[3:2]);
    if (y == 0) return 34'h0;
    q = x / y;
    m = x % y;
    if (m != 0 && c[9:8] == 2'h1 && (x < 0) == (y < 0)) q = q + 1;
    if (c[9:8] == 2'h2 && 2 * (m < 0 ? -m : m) >= (y < 0 ? -y : y))
      q = q + (((x < 0) == (y < 0)) ? 1 : -1);
    lo = c[5] ? 64'sh0 : (c[4] ? -64'sh8000_0000 : -64'sh8000);
    hi = c[5] ? (c[4] ? 64'shFFFF_FFFF : 64'shFFFF) : (c[4] ? 64'sh7FFF_FFFF : 64'sh7FFF);
    d = q < lo ? 2'h1 : (q > hi ? 2'h2 : 2'h0);
    return {d, d != 2'h0 ? 32'h0 : q[31:0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input logic rn, input logic [31:0] a, b);
    logic [33:0] e;
    logic [2:0] nx;
    logic ak;
    @(posedge sys_clk);
    logic_cycle_tick <= 1'b1;
    block_run_enable <= rn;
    dividend_in <= a;
    divisor_in <= b;
    ack_delay <= 4'($random(seed));
    @(negedge sys_clk);
    ak = group_error_acknowledge;
    @(posedge sys_clk);
    logic_cycle_tick <= 1'b0;
    e = exp_div(a, b, ctrl);
    if (st == C_ERR) nx = (e[33:32] == 2'h0 && ak) ? C_RST : C_ERR;
    else nx = !rn ? C_STOP : (e[33:32] == 2'h0 ? C_RUN : C_ERR);
    if (nx == C_ERR && st != C_ERR) begin
      exp_text = e[32] ? 16'h4080 : 16'h4081;
      exp_a = a;
      exp_b = b;
      n_exp++;
      exp_irq[1:0] = exp_irq[1:0] | e[33:32];
    end
    if (nx == C_RST && st != C_RST) exp_irq[3] = 1'b1;
    if (nx == C_RUN && ext(ctrl[7] ? b : 32'h0, ctrl[3:2]) == 0) exp_irq[2] = 1'b1;
    st = nx;
    @(negedge sys_clk);
    chk({state_code_out, error_out}, {st, st == C_ERR});
    chk(quotient_out, st == C_RUN ? e[31:0] : 32'h0);
    chk(diag_code_out, e[33:32]);
    chk({state_to_image, diagnostic_to_image}, {ctrl[10] ? st : 3'h0,
      ctrl[11] ? e[33:32] : 2'h0});
  endtask
  always @(posedge sys_clk) begin
    if (diag_msg_valid === 1'b1) begin
      n_msg++;
      chk({diag_msg_text_id, diag_msg_block_num}, {exp_text, blk});
      chk({diag_msg_param_dividend, diag_msg_param_divisor}, {exp_a, exp_b});
    end
  end
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
  initial begin
    logic [31:0] a, b;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, sid_pkg::SID_CTRL_OFS, 32'h0);
    chk(r, 33'h0C5);
    apb(1'b0, sid_pkg::SID_STATUS_OFS, 32'h0);
    chk(r, 33'h2);
    apb(1'b0, 8'h1C, 32'h0);
    chk(r, 33'h1_0000_0000);
    apb(1'b1, sid_pkg::SID_IRQ_EN_OFS, 32'h0);
    blk = 16'($random(seed));
    apb(1'b1, sid_pkg::SID_BLKNUM_OFS, {16'h0, blk});
    for (int i = 0; i < 4; i++) begin
      ctrl = {2'h3, 2'(i), 8'hC5};
      apb(1'b1, sid_pkg::SID_CTRL_OFS, {20'h0, ctrl});
      for (int j = 0; j < 5; j++) tick(1'b1, ca[j], cb[j]);
      tick(1'b0, 32'h6, 32'h3);
      repeat (8) tick(1'b1, 32'h6, 32'h3);
    end
    ctrl = 12'h0E5;
    apb(1'b1, sid_pkg::SID_CTRL_OFS, {20'h0, ctrl});
    tick(1'b1, 32'hFFFF_FFFC, 32'h2);
    apb(1'b0, sid_pkg::SID_STATUS_OFS, 32'h0);
    chk(r, {26'h0, st == C_ERR, 2'h1, 1'b0, st});
    repeat (40) begin
      ctrl = 12'($random(seed));
      apb(1'b1, sid_pkg::SID_CTRL_OFS, {20'h0, ctrl});
      repeat (8) begin
        a = $random(seed);
        b = $random(seed);
        if (b[31]) b = b & 32'h3;
        if (!ctrl[0]) a[31:16] = 16'h0;
        if (!ctrl[2]) b[31:16] = 16'h0;
        tick(($random(seed) & 7) != 0, a, b);
      end
    end
    apb(1'b0, sid_pkg::SID_IRQ_STAT_OFS, 32'h0);
    chk({r, irq}, {29'h0, exp_irq, 1'b0});
    apb(1'b1, sid_pkg::SID_IRQ_EN_OFS, 32'hF);
    @(negedge sys_clk);
    chk(irq, |exp_irq);
    apb(1'b1, sid_pkg::SID_IRQ_CLR_OFS, 32'hF);
    apb(1'b0, sid_pkg::SID_IRQ_STAT_OFS, 32'h0);
    chk({r, irq}, 34'h0);
    chk(n_msg, n_exp);
    tick(1'b1, 32'h6, 32'h3);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(negedge sys_clk);
    chk({state_code_out, quotient_out}, {C_STOP, 32'h0});
    @(posedge sys_clk);
    rst_b <= 1'b1;
    st = C_STOP;
    ctrl = 12'h0C5;
    blk = sid_pkg::SID_BLKNUM_RESET;
    apb(1'b0, sid_pkg::SID_BLKNUM_OFS, 32'h0);
    chk(r, {17'h0, blk});
    tick(1'b1, 32'h8, 32'h2);
    apb(1'b0, sid_pkg::SID_QUOT_OFS, 32'h0);
    chk(r, 33'h4);
    stop_test();
  end
endmodule // sid_divide_block_tb_top
bind sid_divide_block sid_divide_block_properties u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .logic_cycle_tick(logic_cycle_tick), .divisor_in(divisor_in),
  .block_run_enable(block_run_enable), .group_error_acknowledge(group_error_acknowledge),
  .quotient_out(quotient_out), .error_out(error_out), .state_code_out(state_code_out),
  .diag_msg_valid(diag_msg_valid), .diag_msg_text_id(diag_msg_text_id)
);
`default_nettype wire
